// ==== dv/dam_monitor_sva.sv ====
`timescale 1ns/10ps
module dam_monitor_chk (
   input wire logic        clock_in,
   input wire logic        reset_n_in,
   input wire logic        wb_cyc_in,
   input wire logic        wb_stb_in,
   input wire logic        wb_we_in,
   input wire logic [7:0]  wb_adr_in,
   input wire logic [31:0] wb_dat_in,
   input wire logic [31:0] wb_dat_out,
   input wire logic        wb_ack_out,
   input wire logic        mech_damage_in,
   input wire logic        interrupt_request_low_out,
   input wire logic        irq_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (!reset_n_in);
   logic [9:0] msk_q;
   // shadow of the interrupt enables, written at the edge a request is taken
   always_ff @(posedge clock_in) begin
      if (!reset_n_in) msk_q <= 10'h000;
      else if (wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out && wb_adr_in == 8'h04) msk_q <= wb_dat_in[9:0];
   end
   sequence s_req;
      wb_cyc_in && wb_stb_in && !wb_ack_out;
   endsequence
   property p_ack_follows; s_req |=> wb_ack_out; endproperty
   property p_ack_pulse; wb_ack_out |=> !wb_ack_out; endproperty
   property p_ack_cause; wb_ack_out |-> $past(wb_cyc_in && wb_stb_in); endproperty
   property p_pin_pair; irq_out != interrupt_request_low_out; endproperty
   property p_reset_quiet; $rose(reset_n_in) |-> !wb_ack_out && interrupt_request_low_out; endproperty
   property p_unmapped; s_req ##0 (!wb_we_in && wb_adr_in == 8'h20) |=> wb_dat_out == 32'h0000_0000; endproperty
   property p_mech_irq; mech_damage_in && msk_q[1] |-> ##[1:4] irq_out; endproperty
   property p_static_hold; (irq_out && msk_q == 10'h002) ##1 (msk_q == 10'h002) |-> irq_out; endproperty
   a_ack_follows: assert property (p_ack_follows) else $error("request not acknowledged next cycle");
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   a_pin_pair: assert property (p_pin_pair) else $error("interrupt pins disagree");
   a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_mech_irq: assert property (p_mech_irq) else $error("damage did not interrupt");
   a_static_hold: assert property (p_static_hold) else $error("static interrupt dropped");
endmodule : dam_monitor_chk
bind dam_monitor dam_monitor_chk u_chk (.clock_in, .reset_n_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
   .wb_dat_in, .wb_dat_out, .wb_ack_out, .mech_damage_in, .interrupt_request_low_out, .irq_out);

// ==== dv/dam_monitor_tb_top.sv ====
`timescale 1ns/10ps
module dam_monitor_tb_top import dam_pkg::*; ;
   logic        clock_in, reset_n_in, cyc, we, run, ack, irq, irq_low, tick;
   logic [7:0]  adr;
   logic [9:0]  flt;
   logic [31:0] wdat, rdat, fq;
   int          n_mismatch, comparisons;
   int          tmp [5] = '{2, 3, 5, 6, 7};
   initial begin
      clock_in = 1'b0;
      forever #2.5 clock_in = ~clock_in;
   end
   dam_monitor DUT (.clock_in, .reset_n_in, .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr),
      .wb_sel_in(4'hF), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .mech_damage_in(flt[1]),
      .out_pair_offset_in(flt[2]), .out_overload_in(flt[3]), .coil_short_in(flt[4]),
      .second_receiver_coil_fail_in(flt[5]), .first_receiver_coil_fail_in(flt[6]),
      .single_bit_error_detect_in(flt[7]), .double_bit_error_detect_in(flt[8]), .osc_tick_in(tick),
      .interrupt_request_low_out(irq_low), .irq_out(irq));
   dam_osc_model u_osc (.clock_in, .run_in(run), .osc_tick_out(tick));
   task automatic results;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : results
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clock_in);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      n = 0;
      do begin
         @(posedge clock_in);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      cyc <= 1'b0;
      if (ack !== 1'b1) begin
         n_mismatch++;
         results();
      end
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, q);
      check(q, e);
   endtask : rd
   task automatic idle(input int c);
      repeat (c) @(posedge clock_in);
   endtask : idle
   task automatic pins(input logic e);
      check({30'h0000_0000, irq_low, irq}, {30'h0000_0000, !e, e});
   endtask : pins
   ////////////////////////////////////////////////////////////////////////
   initial begin
      reset_n_in = 1'b0;
      cyc = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      wdat = 32'h0000_0000;
      run = 1'b0;
      flt = 10'h010;
      n_mismatch = 0;
      comparisons = 0;
      idle(12);
      reset_n_in <= 1'b1;
      idle(20);
      flt <= 10'h000;
      rd(8'h04, 32'h0000_0000);
      rd(8'h0C, 32'h0000_0000);
      rd(8'h14, 32'h0000_0000);
      rd(8'h18, 32'h0000_FFFF);
      rd(8'h1C, 32'h0000_03E8);
      wr(8'h20, 32'hFFFF_FFFF);
      rd(8'h20, 32'h0000_0000);
      // each temporary fault input except the oscillator: held off by its enable, then raised, then gone
      for (int i = 0; i < 5; i++) begin
         flt <= 10'h001 << tmp[i];
         idle(6);
         pins(1'b0);
         wr(8'h04, 32'h0000_0001 << tmp[i]);
         idle(4);
         pins(1'b1);
         flt <= 10'h000;
         idle(3);
         wr(8'h00, 32'h0000_0001 << tmp[i]);
         idle(4);
         pins(1'b0);
      end
      flt <= 10'h102;
      idle(2);
      flt <= 10'h000;
      idle(6);
      wr(8'h00, 32'h0000_03FF);
      idle(3);
      rd(8'h00, 32'h0000_0112);
      wr(8'h04, 32'h0000_0002);
      idle(4);
      pins(1'b1);
      wr(8'h00, 32'h0000_0002);
      idle(4);
      pins(1'b1);
      wr(8'h04, 32'h0000_0001);
      wr(8'h0C, 32'h0000_000A);
      idle(16);
      rd(8'h00, 32'h0000_0113);
      pins(1'b1);
      wr(8'h0C, 32'h0000_0000);
      wr(8'h1C, 32'h0000_0014);
      run <= 1'b1;
      wr(8'h04, 32'h0000_0200);
      wr(8'h14, 32'h0000_0064);
      idle(60);
      pins(1'b1);
      bus(1'b0, 8'h10, 32'h0000_0000, fq);
      check(32'(fq >= 32'h0000_0005 && fq <= 32'h0000_0006), 32'h0000_0001);
      wr(8'h14, 32'h0000_0000);
      idle(60);
      wr(8'h00, 32'h0000_0200);
      idle(4);
      pins(1'b0);
      // second power-up without the coil short, which then appears too late
      reset_n_in <= 1'b0;
      idle(12);
      reset_n_in <= 1'b1;
      idle(20);
      // watchdog started and stopped before its first expiry: no flag may follow
      wr(8'h0C, 32'h0000_000A);
      wr(8'h0C, 32'h0000_0000);
      wr(8'h04, 32'h0000_0002);
      // damage now raises an enabled interrupt, the late short is ignored
      flt <= 10'h012;
      idle(20);
      pins(1'b1);
      rd(8'h00, 32'h0000_0002);
      results();
   end
   initial begin
      idle(20000);
      n_mismatch++;
      results();
   end
endmodule : dam_monitor_tb_top

// ==== dv/dam_osc_model.sv ====
`timescale 1ns/10ps
module dam_osc_model (
   input  wire logic clock_in,
   input  wire logic run_in,
   output logic      osc_tick_out
);
   logic [1:0] div_q;
   // one rising edge every four clocks, held low while stopped
   always_ff @(posedge clock_in) begin
      if (!run_in) div_q <= 2'h0;
      else div_q <= div_q + 2'h1;
   end
   assign osc_tick_out = div_q[1];
endmodule : dam_osc_model

// ==== logic/dam_defines.svh ====
`ifndef DAM_DEFINES_SVH
`define DAM_DEFINES_SVH

// register offsets (byte addresses)
`define DAM_OFF_STATUS   8'h00
`define DAM_OFF_MASK     8'h04
`define DAM_OFF_LIVE     8'h08
`define DAM_OFF_WDOG     8'h0C
`define DAM_OFF_FREQ     8'h10
`define DAM_OFF_FLO      8'h14
`define DAM_OFF_FHI      8'h18
`define DAM_OFF_GATE     8'h1C

// flag bit positions
`define DAM_B_WDOG       0
`define DAM_B_MECH       1
`define DAM_B_OBUF       2
`define DAM_B_OVLD       3
`define DAM_B_SHORT      4
`define DAM_B_COIL2      5
`define DAM_B_COIL1      6
`define DAM_B_SED        7
`define DAM_B_DED        8
`define DAM_B_OSC        9
`define DAM_NFLAGS       10

// reset values
`define DAM_RST_MASK     10'h000
`define DAM_RST_WDOG     32'h0000_0000
`define DAM_RST_FLO      16'h0000
`define DAM_RST_FHI      16'hFFFF
`define DAM_RST_GATE     16'h03E8

// start-up counter end value; the window lasts one cycle more
`define DAM_STARTUP_CYC  16'h0010

`endif

// ==== logic/dam_freq_meter.sv ====
`timescale 1ns/10ps
`include "dam_defines.svh"
module dam_freq_meter #(
   parameter int WIDTH = 16
) (
   input  wire logic             clock_in,
   input  wire logic             reset_n_in,
   input  wire logic             osc_tick_in,
   input  wire logic [WIDTH-1:0] gate_len_in,
   output logic [WIDTH-1:0]      count_out,
   output logic                  update_out
);
   logic [WIDTH-1:0] gate_q;
   logic [WIDTH-1:0] acc_q;
   logic             tick_d1_q;

   // count oscillator edges over a programmable gate of gate_len_in system clocks
   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         gate_q     <= '0;
         acc_q      <= '0;
         count_out  <= '0;
         update_out <= 1'b0;
         tick_d1_q  <= 1'b0;
      end else begin
         tick_d1_q  <= osc_tick_in;
         update_out <= 1'b0;
         if (gate_q >= gate_len_in) begin
            gate_q     <= '0;
            count_out  <= acc_q;
            update_out <= 1'b1;
            acc_q      <= '0;
         end else begin
            gate_q <= gate_q + WIDTH'(1);
            if (osc_tick_in && !tick_d1_q) begin
               acc_q <= acc_q + WIDTH'(1);
            end
         end
      end
   end
endmodule : dam_freq_meter

// ==== logic/dam_monitor.sv ====
`timescale 1ns/10ps
`include "dam_defines.svh"
// Overview of operation
// - nonzero watchdog value starts the timer, first expiry latches its request until reset
// - watchdog expiry sets its flag and restarts the period at once
// - zero watchdog value stops the timer, no further requests
// - coil-to-coil short tested once after reset, held until next reset
// - each receiver coil has its own continuous failure flag
// - output buffer flag when an output pair mean leaves half supply
// - overload flag while output load current exceeds limit
// - mechanical damage monitored continuously, static flag
// - memories guarded by check code, alarm on single or double errors
// - oscillator frequency measured and readable as proportional value
// - host sets frequency limits, flag when value lies outside them
// - static flags stay set until reset
// - temporary flags clear when the fault source goes
// - each diagnostic has its own interrupt enable
// - start-up diagnostics evaluated only in power-up window
module dam_monitor
   import dam_pkg::*;
#(
   parameter int WD_WIDTH = 32,
   parameter int FQ_WIDTH = 16
) (
   input  wire logic        clock_in,
   input  wire logic        reset_n_in,
   input  wire logic        wb_cyc_in,
   input  wire logic        wb_stb_in,
   input  wire logic        wb_we_in,
   input  wire logic [7:0]  wb_adr_in,
   input  wire logic [3:0]  wb_sel_in,
   input  wire logic [31:0] wb_dat_in,
   output logic [31:0]      wb_dat_out,
   output logic             wb_ack_out,
   input  wire logic        mech_damage_in,
   input  wire logic        out_pair_offset_in,
   input  wire logic        out_overload_in,
   input  wire logic        coil_short_in,
   input  wire logic        first_receiver_coil_fail_in,
   input  wire logic        second_receiver_coil_fail_in,
   input  wire logic        single_bit_error_detect_in,
   input  wire logic        double_bit_error_detect_in,
   input  wire logic        osc_tick_in,
   output logic             interrupt_request_low_out,
   output logic             irq_out
);
   localparam int NF = `DAM_NFLAGS;

   logic [NF-1:0]       status_q;
   logic [NF-1:0]       mask_q;
   logic [NF-1:0]       live_d;
   logic [NF-1:0]       sticky_q;
   logic [WD_WIDTH-1:0] wd_reload_q;
   logic [WD_WIDTH-1:0] wd_cnt_q;
   logic                wd_fire_q;
   logic [FQ_WIDTH-1:0] flo_q;
   logic [FQ_WIDTH-1:0] fhi_q;
   logic [FQ_WIDTH-1:0] gate_q;
   logic [FQ_WIDTH-1:0] freq_val;
   logic                freq_upd;
   logic                osc_bad_q;
   logic                short_q;
   logic [15:0]         start_cnt_q;
   dam_phase_t          phase_q;
   logic                access;
   logic                wr;
   logic [31:0]         rd_d;

   ////////////////////////////////////////////////////////////////////////
   // byte-lane merge used by every writable register except status
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   assign access = wb_cyc_in && wb_stb_in && !wb_ack_out;
   assign wr     = access && wb_we_in;

   ////////////////////////////////////////////////////////////////////////
   // start-up phase
   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         phase_q     <= DAM_PH_STARTUP;
         start_cnt_q <= '0;
      end else begin
         case (phase_q)
            DAM_PH_STARTUP: begin
               start_cnt_q <= start_cnt_q + 16'h0001;
               if (start_cnt_q == `DAM_STARTUP_CYC) begin
                  phase_q <= DAM_PH_RUN;
               end
            end
            DAM_PH_RUN:    phase_q <= DAM_PH_RUN;
            default:       phase_q <= DAM_PH_STARTUP;
         endcase
      end
   end

   // coil short sampled only during start-up, held until reset
   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         short_q <= 1'b0;
      end else if (phase_q == DAM_PH_STARTUP && coil_short_in) begin
         short_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // watchdog
   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         wd_reload_q <= WD_WIDTH'(`DAM_RST_WDOG);
      end else if (wr && wb_adr_in == `DAM_OFF_WDOG) begin
         wd_reload_q <= WD_WIDTH'(merge(32'(wd_reload_q), wb_dat_in, wb_sel_in));
      end
   end

   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         wd_cnt_q  <= '0;
         wd_fire_q <= 1'b0;
      end else begin
         wd_fire_q <= 1'b0;
         if (wd_reload_q == '0) begin
            wd_cnt_q <= '0;
         end else if (wd_cnt_q == '0) begin
            wd_cnt_q <= wd_reload_q;
         end else if (wd_cnt_q == WD_WIDTH'(1)) begin
            wd_cnt_q  <= wd_reload_q;
            wd_fire_q <= 1'b1;
         end else begin
            wd_cnt_q <= wd_cnt_q - WD_WIDTH'(1);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // oscillator frequency
   dam_freq_meter #(
      .WIDTH(FQ_WIDTH)
   ) u_meter (
      .clock_in    (clock_in),
      .reset_n_in  (reset_n_in),
      .osc_tick_in (osc_tick_in),
      .gate_len_in (gate_q),
      .count_out   (freq_val),
      .update_out  (freq_upd)
   );

   // lower frequency limit
   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         flo_q <= FQ_WIDTH'(`DAM_RST_FLO);
      end else if (wr && wb_adr_in == `DAM_OFF_FLO) begin
         flo_q <= FQ_WIDTH'(merge(32'(flo_q), wb_dat_in, wb_sel_in));
      end
   end

   // upper frequency limit
   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         fhi_q <= FQ_WIDTH'(`DAM_RST_FHI);
      end else if (wr && wb_adr_in == `DAM_OFF_FHI) begin
         fhi_q <= FQ_WIDTH'(merge(32'(fhi_q), wb_dat_in, wb_sel_in));
      end
   end

   // measurement gate length in clocks
   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         gate_q <= FQ_WIDTH'(`DAM_RST_GATE);
      end else if (wr && wb_adr_in == `DAM_OFF_GATE) begin
         gate_q <= FQ_WIDTH'(merge(32'(gate_q), wb_dat_in, wb_sel_in));
      end
   end

   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         osc_bad_q <= 1'b0;
      end else if (freq_upd) begin
         osc_bad_q <= (freq_val < flo_q) || (freq_val > fhi_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // flag sources
   always_comb begin
      live_d = '0;
      live_d[`DAM_B_WDOG]  = wd_fire_q;
      live_d[`DAM_B_MECH]  = mech_damage_in;
      live_d[`DAM_B_OBUF]  = out_pair_offset_in;
      live_d[`DAM_B_OVLD]  = out_overload_in;
      live_d[`DAM_B_SHORT] = short_q;
      live_d[`DAM_B_COIL2] = second_receiver_coil_fail_in;
      live_d[`DAM_B_COIL1] = first_receiver_coil_fail_in;
      live_d[`DAM_B_SED]   = single_bit_error_detect_in;
      live_d[`DAM_B_DED]   = double_bit_error_detect_in;
      live_d[`DAM_B_OSC]   = osc_bad_q;
   end

   // static flags latch until reset, temporary ones follow the source
   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         sticky_q <= '0;
      end else begin
         sticky_q[`DAM_B_WDOG]  <= sticky_q[`DAM_B_WDOG]  | live_d[`DAM_B_WDOG];
         sticky_q[`DAM_B_MECH]  <= sticky_q[`DAM_B_MECH]  | live_d[`DAM_B_MECH];
         sticky_q[`DAM_B_SHORT] <= sticky_q[`DAM_B_SHORT] | live_d[`DAM_B_SHORT];
         sticky_q[`DAM_B_DED]   <= sticky_q[`DAM_B_DED]   | live_d[`DAM_B_DED];
         sticky_q[`DAM_B_OBUF]  <= live_d[`DAM_B_OBUF];
         sticky_q[`DAM_B_OVLD]  <= live_d[`DAM_B_OVLD];
         sticky_q[`DAM_B_COIL2] <= live_d[`DAM_B_COIL2];
         sticky_q[`DAM_B_COIL1] <= live_d[`DAM_B_COIL1];
         sticky_q[`DAM_B_SED]   <= live_d[`DAM_B_SED];
         sticky_q[`DAM_B_OSC]   <= live_d[`DAM_B_OSC];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt status: set on flag, write one to clear, set wins
   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         status_q <= '0;
      end else begin
         for (int i = 0; i < NF; i++) begin
            if (sticky_q[i]) begin
               status_q[i] <= 1'b1;
            end else if (wr && wb_adr_in == `DAM_OFF_STATUS && wb_sel_in[i/8] && wb_dat_in[i]) begin
               status_q[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         mask_q <= `DAM_RST_MASK;
      end else if (wr && wb_adr_in == `DAM_OFF_MASK) begin
         mask_q <= NF'(merge(32'(mask_q), wb_dat_in, wb_sel_in));
      end
   end

   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         irq_out                   <= 1'b0;
         interrupt_request_low_out <= 1'b1;
      end else begin
         irq_out                   <= |(status_q & mask_q);
         interrupt_request_low_out <= ~|(status_q & mask_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bus read path
   always_comb begin
      case (wb_adr_in)
         `DAM_OFF_STATUS: rd_d = 32'(status_q);
         `DAM_OFF_MASK:   rd_d = 32'(mask_q);
         `DAM_OFF_LIVE:   rd_d = 32'(sticky_q);
         `DAM_OFF_WDOG:   rd_d = 32'(wd_reload_q);
         `DAM_OFF_FREQ:   rd_d = 32'(freq_val);
         `DAM_OFF_FLO:    rd_d = 32'(flo_q);
         `DAM_OFF_FHI:    rd_d = 32'(fhi_q);
         `DAM_OFF_GATE:   rd_d = 32'(gate_q);
         default:         rd_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= 32'h0000_0000;
      end else begin
         wb_ack_out <= access;
         if (access && !wb_we_in) begin
            wb_dat_out <= rd_d;
         end
      end
   end
endmodule : dam_monitor

// ==== logic/dam_pkg.sv ====
package dam_pkg;
   typedef enum logic [1:0] {
      DAM_PH_STARTUP,
      DAM_PH_RUN
   } dam_phase_t;
endpackage : dam_pkg
